// File: inc/sleep_ctl_defs.vh
`ifndef SLEEP_CTL_DEFS_VH
`define SLEEP_CTL_DEFS_VH

// Register word addresses
`define ADDR_CONTROL 4'h0
`define ADDR_RAW_STATUS 4'h1
`define ADDR_IRQ_MASK 4'h2
`define ADDR_MASKED_STATUS 4'h3
`define ADDR_IRQ_CLEAR 4'h4
`define ADDR_STATE 4'h5

// Control word bit positions
`define CTL_SLEEP_REQUEST 0
`define CTL_ALARM_RESUME_EN 1
`define CTL_SLOW_CLOCK_SELECT 2
`define CTL_PIN_RESUME_EN 3
`define CTL_LOW_BATTERY_DETECT_EN 4
`define CTL_LOW_BATTERY_ABORT 5
`define CTL_SLOW_CLOCK_ENABLE 6
`define CTL_WIDTH 7

// Event bit positions (raw status, mask, clear)
`define EVT_ALARM 0
`define EVT_BATTERY_LOW 2
`define EVT_RESUME_PIN 3
`define EVT_WIDTH 4

// Reset values
`define CONTROL_RESET 7'h00
`define EVENT_RESET 4'h0

// Crystal divide ratio and counter width
`define CRYSTAL_DIVIDE 128
`define CRYSTAL_DIV_HALF 64
`define DIV_WIDTH 7

// Slow-domain edge sync depth after the slow tick
`define SYNC_STAGES 2

`endif

// File: src/sleep_power_ctl.v
// Behaviour
// - Power-off output held low exactly while in sleep, released otherwise.
// - In sleep, pin resume or alarm match releases power-off output.
// - Dedicated resume pin asserted wakes the device from sleep.
// - Wake returns supply; system gets a full power-on reset afterwards.
// - Back-to-back reads are accepted with no gap.
// - Slow clock enable starts the clock source; logic runs from it.
// - Select 0 divides crystal input by 128; select 1 uses it directly.
// - With detection on and battery low, set the battery-low flag.
// - With abort set and battery low, a sleep request is refused.
// - Battery-low event raises the interrupt when unmasked.
// - Battery level is neither sampled nor updated while sleeping.
// - Setting the sleep request bit asserts the power-off output.
// - At least one wake source enabled before sleep; either or both.
// - Alarm, pin and battery events ORed onto one interrupt line.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_ctl_defs.vh"

module sleep_power_ctl
#(
    // Divider counter width; the crystal is divided by two to this power
    parameter DIV_WIDTH = `DIV_WIDTH
)
(
    input wire core_clk,
    input wire resetn,
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [31:0] reg_rdata,
    input wire slow_osc_in,
    output reg slow_osc_out,
    input wire resume_pin_n,
    input wire alarm_match,
    input wire battery_below_threshold,
    output reg sleep_power_off_n_out,
    output reg sleep_power_off_n_oe,
    output reg slow_tick,
    output reg irq
);

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers: first stage read only by the second

// Stage 0 catches metastability; only stage 1 feeds any logic
reg [1:0] osc_sync_q;
reg [1:0] resume_sync_q;
reg [1:0] alarm_sync_q;
reg [1:0] batt_sync_q;

// Two flops per asynchronous input; the resume pair resets high, its
// idle level, so no false press is seen after reset
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
    begin
        osc_sync_q <= 2'b00;
        resume_sync_q <= 2'b11;
        alarm_sync_q <= 2'b00;
        batt_sync_q <= 2'b00;
    end
    else
    begin
        osc_sync_q <= {osc_sync_q[0], slow_osc_in};
        resume_sync_q <= {resume_sync_q[0], resume_pin_n};
        alarm_sync_q <= {alarm_sync_q[0], alarm_match};
        batt_sync_q <= {batt_sync_q[0], battery_below_threshold};
    end
end

////////////////////////////////////////////////////////////////////////////
// Control word

// Software-visible state, plus the internal sleep flag
reg [`CTL_WIDTH-1:0] ctl_q;
reg [`EVT_WIDTH-1:0] raw_q;
reg [`EVT_WIDTH-1:0] mask_q;
reg asleep_q;

// Write decodes; unmapped words fall through and are ignored
wire wr_ctl = reg_write && (reg_addr == `ADDR_CONTROL);
wire wr_mask = reg_write && (reg_addr == `ADDR_IRQ_MASK);
wire wr_clr = reg_write && (reg_addr == `ADDR_IRQ_CLEAR);

// Request bit self-clears once the slow domain has acted on it
wire req_taken;

// Software owns every bit; hardware only clears the request
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
        ctl_q <= `CONTROL_RESET;
    else if (wr_ctl)
        ctl_q <= reg_wdata[`CTL_WIDTH-1:0];
    else if (req_taken)
        ctl_q[`CTL_SLEEP_REQUEST] <= 1'b0;
end

// Enable and source select, read all over the slow logic
wire clk_en = ctl_q[`CTL_SLOW_CLOCK_ENABLE];
wire clk_sel = ctl_q[`CTL_SLOW_CLOCK_SELECT];

////////////////////////////////////////////////////////////////////////////
// Slow clock source: crystal divided, or oscillator used directly

// Edge memory, divider and reference
reg osc_prev_q;
reg [DIV_WIDTH-1:0] div_q;
reg slow_ref_q;
reg slow_prev_q;

wire osc_rise = osc_sync_q[1] && !osc_prev_q;
// Divider period is two to the counter width in input edges; top bit
// low marks the first half, where the reference is high
wire div_ref = !div_q[DIV_WIDTH-1];

// Oscillator edge counting; a 4 MHz input still fits under 100 MHz.
// Limitation: inputs above half of core_clk alias in the sync
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
    begin
        osc_prev_q <= 1'b0;
        div_q <= {DIV_WIDTH{1'b0}};
        slow_ref_q <= 1'b0;
        slow_prev_q <= 1'b0;
    end
    else
    begin
        osc_prev_q <= osc_sync_q[1];
        if (!clk_en)
            div_q <= {DIV_WIDTH{1'b0}};
        else if (osc_rise)
            div_q <= div_q + 1'b1;
        slow_ref_q <= clk_en && (clk_sel ? osc_sync_q[1] : div_ref);
        slow_prev_q <= slow_ref_q;
    end
end

// One-cycle tick on each rising edge of the slow reference
wire tick = slow_ref_q && !slow_prev_q;

// Registered so both outputs come straight from flops
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
    begin
        slow_tick <= 1'b0;
        slow_osc_out <= 1'b0;
    end
    else
    begin
        slow_tick <= tick;
        slow_osc_out <= clk_en && !clk_sel && !osc_sync_q[1]; // Crystal drive
    end
end

////////////////////////////////////////////////////////////////////////////
// Slow-domain sleep state machine, advanced on slow ticks except waking to awake, one core cycle later

// One-hot states
localparam ST_AWAKE = 3'b001;
localparam ST_ASLEEP = 3'b010;
localparam ST_WAKING = 3'b100;

reg [2:0] state_q;
reg [2:0] state_d;
reg req_seen_q;
reg batt_low_q;

// Wake causes count only while their enable bit is set
wire pin_wake = !resume_sync_q[1] && ctl_q[`CTL_PIN_RESUME_EN];
wire alarm_wake = alarm_sync_q[1] && ctl_q[`CTL_ALARM_RESUME_EN];
wire abort = ctl_q[`CTL_LOW_BATTERY_ABORT] && batt_low_q;
wire any_wake_en = ctl_q[`CTL_PIN_RESUME_EN] || ctl_q[`CTL_ALARM_RESUME_EN];

// Request is acted on at the next slow tick only, as the slow domain would
// Limitation: with the slow clock off a request waits indefinitely
assign req_taken = tick && ctl_q[`CTL_SLEEP_REQUEST] && !req_seen_q;

// Next state
always @*
begin
    state_d = state_q;
    case (state_q)
        ST_AWAKE:
            // A refused request is dropped; the bit still clears
            if (req_taken && !abort && any_wake_en)
                state_d = ST_ASLEEP;
        ST_ASLEEP:
            // Wake causes are looked at on the tick only
            if (tick && (pin_wake || alarm_wake))
                state_d = ST_WAKING;
        ST_WAKING:
            // Supply returns; the system sees a power-on reset
            state_d = ST_AWAKE;
        default:
            state_d = ST_AWAKE;
    endcase
end

// State, request memory and the sleep flag that gates the battery
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
    begin
        state_q <= ST_AWAKE;
        req_seen_q <= 1'b0;
        asleep_q <= 1'b0;
    end
    else
    begin
        state_q <= state_d;
        req_seen_q <= req_taken;
        asleep_q <= (state_d == ST_ASLEEP);
    end
end

////////////////////////////////////////////////////////////////////////////
// Battery level, frozen while asleep

// Detection off clears the level; asleep holds it, the sense being off
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
        batt_low_q <= 1'b0;
    else if (!asleep_q && ctl_q[`CTL_LOW_BATTERY_DETECT_EN])
        batt_low_q <= batt_sync_q[1];
    else if (!ctl_q[`CTL_LOW_BATTERY_DETECT_EN])
        batt_low_q <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////
// Power-off pin: open drain, driven low only while asleep

// Data tied low; the enable alone pulls the pin. It follows the next
// state so it lands on the tick edge itself
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
    begin
        sleep_power_off_n_out <= 1'b0;
        sleep_power_off_n_oe <= 1'b0;
    end
    else
    begin
        sleep_power_off_n_out <= 1'b0;
        sleep_power_off_n_oe <= (state_d == ST_ASLEEP);
    end
end

////////////////////////////////////////////////////////////////////////////
// Events, sticky status, mask and interrupt

// One bit per source, in status layout
reg [`EVT_WIDTH-1:0] evt;

// Event sources; battery flag only while detection is enabled
always @*
begin
    evt = `EVENT_RESET;
    // Pin and alarm set their bits whether or not they may wake
    evt[`EVT_ALARM] = alarm_sync_q[1];
    evt[`EVT_RESUME_PIN] = !resume_sync_q[1];
    evt[`EVT_BATTERY_LOW] = batt_low_q;
end

// Set wins over a write-one clear in the same cycle
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
        raw_q <= `EVENT_RESET;
    else
        raw_q <= (raw_q & ~(wr_clr ? reg_wdata[`EVT_WIDTH-1:0] :
                  `EVENT_RESET)) | evt;
end

// Mask, same layout as the raw status
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
        mask_q <= `EVENT_RESET;
    else if (wr_mask)
        mask_q <= reg_wdata[`EVT_WIDTH-1:0];
end

// Single request line from all sources
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
        irq <= 1'b0;
    else
        irq <= |(raw_q & mask_q);
end

////////////////////////////////////////////////////////////////////////////
// Read port: any register, any spacing, data one cycle later

// Next read word
reg [31:0] rd_d;

// Read multiplexer; the clear word and unmapped words read as zero
always @*
begin
    rd_d = 32'h0000_0000;
    case (reg_addr)
        `ADDR_CONTROL:
            rd_d[`CTL_WIDTH-1:0] = ctl_q;
        `ADDR_RAW_STATUS:
            rd_d[`EVT_WIDTH-1:0] = raw_q;
        `ADDR_IRQ_MASK:
            rd_d[`EVT_WIDTH-1:0] = mask_q;
        `ADDR_MASKED_STATUS:
            rd_d[`EVT_WIDTH-1:0] = raw_q & mask_q;
        `ADDR_STATE:
            rd_d[3:0] = {batt_low_q, state_q};
        default:
            rd_d = 32'h0000_0000;
    endcase
end

// Data stand one cycle, then zero, so stale words never linger
always @(posedge core_clk or negedge resetn)
begin
    if (!resetn)
        reg_rdata <= 32'h0000_0000;
    else if (reg_read)
        reg_rdata <= rd_d;
    else
        reg_rdata <= 32'h0000_0000;
end

endmodule // sleep_power_ctl
`default_nettype wire

// File: testbench/power_ctl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module power_ctl_chk (
    input wire core_clk,
    input wire resetn,
    input wire reg_write,
    input wire reg_read,
    input wire [31:0] reg_rdata,
    input wire slow_osc_in,
    input wire slow_osc_out,
    input wire resume_pin_n,
    input wire alarm_match,
    input wire sleep_power_off_n_out,
    input wire sleep_power_off_n_oe,
    input wire slow_tick,
    input wire irq
);
    // One domain, so one clock and one disable for all
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_rdata_idle: assert property (!reg_read |=> reg_rdata == 0)
        else $error("read data outside its slot");
    a_drain_low: assert property (sleep_power_off_n_out == 1'b0)
        else $error("open-drain data not low");
    a_sleep_tick: assert property ($rose(sleep_power_off_n_oe)
        |-> slow_tick)
        else $error("power-off rose off tick");
    a_wake_tick: assert property ($fell(sleep_power_off_n_oe)
        |-> slow_tick)
        else $error("power-off fell off tick");
    // Crystal drive is the inverse of the input, three samples late
    a_drive_phase: assert property (slow_osc_out
        |-> !$past(slow_osc_in, 3))
        else $error("crystal drive not inverse of input");
    a_stay_off: assert property (sleep_power_off_n_oe && resume_pin_n
        && !alarm_match [*8] |=> sleep_power_off_n_oe)
        else $error("woke with no wake cause");
    a_tick_pulse: assert property (slow_tick |=> !slow_tick)
        else $error("tick longer than one cycle");
    a_tick_osc: assert property ($stable(slow_osc_in) [*8] |=> !slow_tick)
        else $error("tick with reference still");
    a_irq_clear: assert property ($fell(irq) |-> $past(reg_write)
        || $past(reg_write, 2) || $past(reg_write, 3))
        else $error("interrupt fell with no write");
endmodule // power_ctl_chk
bind sleep_power_ctl power_ctl_chk u_chk (
    .core_clk(core_clk), .resetn(resetn), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .slow_osc_in(slow_osc_in),
    .resume_pin_n(resume_pin_n), .alarm_match(alarm_match), .irq(irq),
    .sleep_power_off_n_out(sleep_power_off_n_out), .slow_tick(slow_tick),
    .sleep_power_off_n_oe(sleep_power_off_n_oe),
    .slow_osc_out(slow_osc_out)
);
`default_nettype wire

// File: testbench/regulator_model.sv
`timescale 1ns/100ps
`default_nettype none
module regulator_model (
    input wire logic core_clk,
    input wire logic osc_run,
    input wire logic press,
    input wire logic off_oe,
    output logic osc,
    output logic wake_n,
    output logic powered
);
    logic [2:0] ph = 3'h0;
    // Reference of eight cycles; stands still while not running
    always @(posedge core_clk)
        ph <= osc_run ? ph + 3'h1 : ph;
    assign osc = ph[2];
    assign wake_n = !press; // Pull-up holds the pin high when released
    assign powered = !off_oe; // Regulator on while drain released
endmodule // regulator_model
`default_nettype wire

// File: testbench/test_sleep_power_ctl.sv
`timescale 1ns/100ps
`default_nettype none
`include "sleep_ctl_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("MISMATCH t=%0t value differs", $time); end end
module test_sleep_power_ctl;
    logic core_clk = 0, resetn = 0, reg_write = 0, reg_read = 0, pend = 0;
    logic alarm_match = 0, battery_below_threshold = 0, osc_run = 0, press = 0;
    logic [3:0] reg_addr = 0;
    logic [31:0] reg_wdata = 0;
    logic [7:0] lf = 8'h59;
    wire [31:0] reg_rdata;
    wire osc, wake_n, off_out, off_oe, slow_tick, irq, powered;
    wire osc_drv;
    int err_count = 0, tests_run = 0, n, i;
    logic [31:0] expq[$];
    ////////////////////////////////////////
    initial forever #5 core_clk = ~core_clk;
    sleep_power_ctl DUT (.core_clk(core_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .slow_osc_in(osc),
        .slow_osc_out(osc_drv), .resume_pin_n(wake_n),
        .alarm_match(alarm_match),
        .battery_below_threshold(battery_below_threshold), .irq(irq),
        .sleep_power_off_n_out(off_out), .sleep_power_off_n_oe(off_oe),
        .slow_tick(slow_tick));
    regulator_model reg_far (.core_clk(core_clk), .osc_run(osc_run),
        .press(press), .off_oe(off_oe), .osc(osc), .wake_n(wake_n),
        .powered(powered));
    ////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Idle cycle after each strobe so no signal is driven twice at one edge
    task wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        @(posedge core_clk); // Gap before the next access
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        expq.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    task ticks(input int c);
        n = 0;
        repeat (c) begin @(posedge core_clk); n += (slow_tick === 1'b1); end
    endtask
    // Bounded wait; running out ends the run
    task wait_oe(input logic v);
        for (n = 0; n < 3000 && off_oe !== v; n++) @(posedge core_clk);
        `CHK(off_oe, v)
        if (off_oe !== v) final_report();
    endtask
    task final_report;
        $display("compares %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge core_clk)
    begin
        pend <= reg_read;
        if (pend) `CHK(reg_rdata, expq.pop_front())
    end
    ////////////////////////////////////////
    initial
    begin
        cyc(16);
        resetn <= 1'b1;
        cyc(1);
        rd(`ADDR_CONTROL, 0);
        rd(`ADDR_STATE, 32'h0000_0001);
        for (i = 0; i < 8; i++)
        begin
            lf = lfsr(lf);
            wr({1'b1, lf[2:0]}, {4{lf}});
            rd({1'b1, lf[2:0]}, 0);
        end
        osc_run <= 1'b1;
        wr(`ADDR_CONTROL, 32'h0000_0044);
        ticks(800);
        `CHK(n inside {[99:101]}, 1'b1)
        `CHK(osc_drv, 1'b0)
        wr(`ADDR_CONTROL, 32'h0000_0040);
        ticks(2048);
        `CHK(n inside {[2:3]}, 1'b1)
        battery_below_threshold <= 1'b1;
        wr(`ADDR_CONTROL, 32'h0000_0074);
        wr(`ADDR_IRQ_MASK, 32'h0000_0004);
        cyc(8);
        rd(`ADDR_RAW_STATUS, 32'h0000_0004);
        `CHK(irq, 1'b1)
        wr(`ADDR_CONTROL, 32'h0000_0075);
        cyc(100);
        `CHK(off_oe, 1'b0)
        battery_below_threshold <= 1'b0;
        cyc(8);
        wr(`ADDR_IRQ_CLEAR, 32'h0000_0004);
        cyc(4);
        `CHK(irq, 1'b0)
        wr(`ADDR_CONTROL, 32'h0000_0045);
        cyc(100);
        `CHK(off_oe, 1'b0)
        wr(`ADDR_CONTROL, 32'h0000_005D);
        wait_oe(1'b1);
        battery_below_threshold <= 1'b1;
        cyc(40);
        rd(`ADDR_STATE, 32'h0000_0002);
        battery_below_threshold <= 1'b0;
        cyc(8);
        press <= 1'b1;
        wait_oe(1'b0);
        `CHK(powered, 1'b1)
        press <= 1'b0;
        cyc(8);
        rd(`ADDR_RAW_STATUS, 32'h0000_0008);
        rd(`ADDR_STATE, 32'h0000_0001);
        wr(`ADDR_IRQ_CLEAR, 32'h0000_000F);
        wr(`ADDR_CONTROL, 32'h0000_0047);
        wait_oe(1'b1);
        alarm_match <= 1'b1;
        wait_oe(1'b0);
        alarm_match <= 1'b0;
        wr(`ADDR_IRQ_MASK, 32'h0000_0001);
        cyc(4);
        `CHK(irq, 1'b1)
        final_report();
    end
endmodule // test_sleep_power_ctl
`default_nettype wire
